/* hw/rx_fifo.sv */
// Purpose: receive byte buffer between shift engine and register reads
// Assumes: DEPTH is a power of two
// Notes: no reset on storage, only on pointers
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer update
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + (AW+1)'(1);
      end
      if (pop) begin
        rd_q <= rd_q + (AW+1)'(1);
      end
    end
  end

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

endmodule
`default_nettype wire

/* hw/serial_port_ctrl.sv */
// Purpose: control/status, data buffering and byte engine of the serial port
// Assumes: link pins are asynchronous and pass two flip-flops
// Notes: clock mode 0 only, msb first, fixed sck rate in master operation
`timescale 1ns/1ps
`default_nettype none
module serial_port_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // special function register access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [serial_port_pkg::DATA_W-1:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_idx,
  input wire logic sfr_bit_val,
  output logic [serial_port_pkg::DATA_W-1:0] sfr_rdata,
  // interrupt
  input wire logic int_enable,
  output logic irq,
  // link pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_b,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_b,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_b,
  input wire logic nss_in,
  output logic nss_out,
  output logic nss_oe_b
);
  import serial_port_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] prev_q;
  logic done_q, write_collision_flag_q, mode_fault_flag_q, ovr_q, txe_q, en_q, master_enable_q;
  sel_mode_t mode_q;
  logic [7:0] tx_buf_q, sh_q, rdata_q;
  logic [3:0] bit_cnt_q;
  logic [2:0] half_q;
  logic sck_q, samp_q, irq_q;
  logic sck_oe_q, mosi_oe_q, miso_oe_q, nss_oe_q, nss_out_q;
  eng_state_t state_q;
  logic sck_s, mosi_s, miso_s, nss_s, sck_rise, sck_fall;
  logic ctrl_wr, bit_op, dat_wr, dat_rd, wr_ok, collide;
  logic [7:0] ctrl_now, ctrl_sw, cfg_now;
  logic slave_sel, master_fault, start_m, start_s, slv_load, load;
  logic tick, m_done, s_done, byte_done, mode_lo;
  logic [7:0] rx_byte;
  logic [3:0] keep_mask;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // order {nss, miso, mosi, sck}; sync_q and prev_q are looked at, meta_q is not
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= SYNC_RESET;
      sync_q <= SYNC_RESET;
      prev_q <= SYNC_RESET;
    end else begin
      meta_q <= {nss_in, miso_in, mosi_in, sck_in};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sck_s = sync_q[0];
  assign mosi_s = sync_q[1];
  assign miso_s = sync_q[2];
  assign nss_s = sync_q[3];
  assign sck_rise = sck_s && !prev_q[0];
  assign sck_fall = !sck_s && prev_q[0];

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  assign ctrl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
  assign bit_op = sfr_bit_wr && (sfr_addr == CTRL_ADDR);
  assign dat_wr = sfr_wr && (sfr_addr == DATA_ADDR);
  assign dat_rd = sfr_rd && (sfr_addr == DATA_ADDR);
  assign wr_ok = dat_wr && txe_q;
  assign collide = dat_wr && !txe_q;
  assign ctrl_now = {done_q, write_collision_flag_q, mode_fault_flag_q, ovr_q, mode_q, txe_q, en_q};
  assign cfg_now = {(state_q == ST_MASTER) || (bit_cnt_q != 4'h0), master_enable_q, 2'h0,
                    slave_sel && !master_enable_q, nss_s, master_enable_q || ((bit_cnt_q == 4'h0) && txe_q),
                    !fifo_out_valid};
  assign mode_lo = mode_q[0];

  // software view of the control register after a byte or single bit write
  always_comb begin
    ctrl_sw = ctrl_now;
    if (ctrl_wr) begin
      ctrl_sw = sfr_wdata;
    end else if (bit_op) begin
      ctrl_sw[sfr_bit_idx] = sfr_bit_val;
    end
  end

  assign keep_mask = ctrl_now[7:4] & ctrl_sw[7:4];

  // ----------------------------------------
  // engine conditions
  // ----------------------------------------
  // select line only counts as input in mode 01
  assign slave_sel = !((mode_q == SEL_4WIRE_IN) && nss_s);
  assign master_fault = master_enable_q && (mode_q == SEL_4WIRE_IN) && !nss_s;
  // master waits for room in the receive buffer
  assign start_m = en_q && master_enable_q && (state_q == ST_IDLE) && !txe_q && fifo_in_ready &&
                   !master_fault;
  assign start_s = en_q && !master_enable_q && slave_sel && (state_q == ST_IDLE);
  assign slv_load = (state_q == ST_SLAVE) && (bit_cnt_q == 4'h0) && !txe_q && !sck_rise &&
                    en_q && !master_enable_q && slave_sel;
  assign load = start_m || (start_s && !txe_q) || slv_load;
  assign tick = (half_q == 3'h0);
  assign m_done = (state_q == ST_MASTER) && tick && sck_q && (bit_cnt_q == BYTE_BITS);
  assign s_done = (state_q == ST_SLAVE) && sck_rise && (bit_cnt_q == (BYTE_BITS - 4'h1));
  assign byte_done = m_done || s_done;
  assign rx_byte = m_done ? {sh_q[6:0], samp_q} : {sh_q[6:0], mosi_s};

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // flags keep software value, hardware only ever sets
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= CTRL_RESET[DONE_BIT];
      write_collision_flag_q <= CTRL_RESET[WRITE_COLLISION_FLAG_BIT];
      mode_fault_flag_q <= CTRL_RESET[MODE_FAULT_FLAG_BIT];
      ovr_q <= CTRL_RESET[OVR_BIT];
      mode_q <= MODE_RESET;
      en_q <= CTRL_RESET[EN_BIT];
    end else begin
      done_q <= ctrl_sw[DONE_BIT] || byte_done;
      write_collision_flag_q <= ctrl_sw[WRITE_COLLISION_FLAG_BIT] || collide;
      mode_fault_flag_q <= ctrl_sw[MODE_FAULT_FLAG_BIT] || master_fault;
      ovr_q <= ctrl_sw[OVR_BIT] || (s_done && !fifo_in_ready);
      mode_q <= sel_mode_t'(ctrl_sw[MODE_HI:MODE_LO]);
      en_q <= ctrl_sw[EN_BIT];
    end
  end

  // configuration register, master enable only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      master_enable_q <= MASTER_ENABLE_RESET;
    end else if (sfr_wr && (sfr_addr == CFG_ADDR)) begin
      master_enable_q <= sfr_wdata[MASTER_ENABLE_BIT];
    end
  end

  // ----------------------------------------
  // transmit buffer
  // ----------------------------------------
  // load and accepted write are exclusive: one needs empty, one full
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      txe_q <= TXE_RESET;
      tx_buf_q <= 8'h00;
    end else if (load) begin
      txe_q <= 1'b1;
    end else if (wr_ok) begin
      txe_q <= 1'b0;
      tx_buf_q <= sfr_wdata;
    end
  end

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  // master: rise samples miso, fall shifts; slave follows synced sck
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      half_q <= SCK_HALF_LOAD;
      sck_q <= 1'b0;
      samp_q <= 1'b0;
      sh_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          bit_cnt_q <= 4'h0;
          half_q <= SCK_HALF_LOAD;
          sck_q <= 1'b0;
          if (start_m) begin
            state_q <= ST_MASTER;
            sh_q <= tx_buf_q;
          end else if (start_s) begin
            state_q <= ST_SLAVE;
            sh_q <= txe_q ? 8'h00 : tx_buf_q;
          end
        end
        ST_MASTER: begin
          if (!en_q || !master_enable_q || master_fault) begin
            state_q <= ST_IDLE;
            sck_q <= 1'b0;
          end else if (!tick) begin
            half_q <= half_q - 3'h1;
          end else begin
            half_q <= SCK_HALF_LOAD;
            sck_q <= !sck_q;
            if (!sck_q) begin
              samp_q <= miso_s;
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (m_done) begin
              state_q <= ST_IDLE;
            end else begin
              sh_q <= {sh_q[6:0], samp_q};
            end
          end
        end
        ST_SLAVE: begin
          if (!en_q || master_enable_q || !slave_sel) begin
            state_q <= ST_IDLE;
          end else if (slv_load) begin
            sh_q <= tx_buf_q;
          end else if (s_done) begin
            state_q <= ST_IDLE;
          end else if (sck_rise) begin
            samp_q <= mosi_s;
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (sck_fall && (bit_cnt_q != 4'h0)) begin
            sh_q <= {sh_q[6:0], samp_q};
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  rx_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(byte_done),
    .in_ready(fifo_in_ready),
    .in_data(rx_byte),
    .out_valid(fifo_out_valid),
    .out_ready(dat_rd),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // read data, interrupt and pin enables
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      sck_oe_q <= 1'b1;
      mosi_oe_q <= 1'b1;
      miso_oe_q <= 1'b1;
      nss_oe_q <= 1'b1;
      nss_out_q <= 1'b1;
    end else begin
      if (sfr_rd) begin
        case (sfr_addr)
          CTRL_ADDR: rdata_q <= ctrl_now;
          CFG_ADDR: rdata_q <= cfg_now;
          DATA_ADDR: rdata_q <= fifo_out_valid ? fifo_out_data : 8'h00;
          default: rdata_q <= 8'h00;
        endcase
      end
      irq_q <= int_enable && (|ctrl_now[7:4]);
      sck_oe_q <= !(en_q && master_enable_q);
      mosi_oe_q <= !(en_q && master_enable_q);
      miso_oe_q <= !(en_q && !master_enable_q && slave_sel);
      nss_oe_q <= !mode_q[1];
      nss_out_q <= mode_lo;
    end
  end

  assign sfr_rdata = rdata_q;
  assign irq = irq_q;
  assign sck_out = sck_q;
  assign sck_oe_b = sck_oe_q;
  assign mosi_out = sh_q[7];
  assign mosi_oe_b = mosi_oe_q;
  assign miso_out = sh_q[7];
  assign miso_oe_b = miso_oe_q;
  assign nss_out = nss_out_q;
  assign nss_oe_b = nss_oe_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence collide_s;
    dat_wr && !txe_q;
  endsequence

  sequence master_go_s;
    start_m ##1 (state_q == ST_MASTER);
  endsequence

  done_flag_a: assert property (byte_done |=> done_q)
    else $error("transfer done flag not set after byte");
  flags_sticky_a: assert property (1'b1 |=> ((ctrl_now[7:4] & $past(keep_mask)) == $past(keep_mask)))
    else $error("event flag cleared without software");
  irq_req_a: assert property ((int_enable && (|ctrl_now[7:4])) |=> irq)
    else $error("interrupt not raised for set flag");
  write_collision_flag_set_a: assert property (collide_s |=> write_collision_flag_q)
    else $error("write collision flag missing");
  tx_kept_a: assert property ((collide_s and !load) |=> ($stable(tx_buf_q) && !txe_q))
    else $error("colliding write changed transmit buffer");
  mode_fault_flag_set_a: assert property (master_fault |=> (mode_fault_flag_q && state_q != ST_MASTER))
    else $error("mode fault not flagged");
  overrun_set_a: assert property ((s_done && !fifo_in_ready) |=> ovr_q)
    else $error("receive overrun not flagged");
  three_wire_a: assert property ((mode_q == SEL_3WIRE) [*2] |-> nss_oe_b)
    else $error("select line driven in three wire mode");
  nss_input_a: assert property ((mode_q == SEL_4WIRE_IN) |=> nss_oe_b)
    else $error("select line driven in input mode");
  nss_drive_a: assert property (mode_q[1] |=> (!nss_oe_b && nss_out == $past(mode_lo)))
    else $error("select output wrong in single master mode");
  txe_clear_a: assert property (wr_ok |=> !txe_q ##1 (!txe_q || $past(load)))
    else $error("buffer empty not cleared on write");
  txe_set_a: assert property (load |=> txe_q)
    else $error("buffer empty not set on load");
  port_off_a: assert property (!en_q |=> (sck_oe_b && miso_oe_b && state_q == ST_IDLE))
    else $error("port active while disabled");
  bit_op_a: assert property ((bit_op && !ctrl_wr && sfr_bit_idx == 3'(EN_BIT)) |=>
                             en_q == $past(sfr_bit_val))
    else $error("single bit write to enable lost");
  master_sck_a: assert property ((en_q && master_enable_q) |=> (!sck_oe_b && !mosi_oe_b))
    else $error("master does not drive clock");
  master_start_a: assert property (master_go_s |-> txe_q ##[1:50] (sck_q == 1'b1))
    else $error("master transfer did not start");
  set_wins_a: assert property ((byte_done && ctrl_wr && !sfr_wdata[DONE_BIT]) |=> done_q)
    else $error("clear won over hardware set");

endmodule
`default_nettype wire

/* hw/serial_port_pkg.sv */
// Purpose: shared constants and types for the serial port control/status block
// Assumes: 250 MHz ref_clk, processor special function register access
// Notes: bit positions are indices into the 8-bit registers
package serial_port_pkg;

  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [7:0] CFG_ADDR = 8'hA1;
  localparam logic [7:0] DATA_ADDR = 8'hA3;
  localparam logic [7:0] CTRL_ADDR = 8'hF8;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int DONE_BIT = 7;
  localparam int WRITE_COLLISION_FLAG_BIT = 6;
  localparam int MODE_FAULT_FLAG_BIT = 5;
  localparam int OVR_BIT = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 2;
  localparam int TXE_BIT = 1;
  localparam int EN_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h06;

  // ----------------------------------------
  // configuration register fields
  // ----------------------------------------
  localparam int MASTER_ENABLE_BIT = 6;
  localparam logic MASTER_ENABLE_RESET = 1'h0;

  // ----------------------------------------
  // select line modes and engine states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEL_3WIRE = 2'b00,
    SEL_4WIRE_IN = 2'b01,
    SEL_DRIVE_LO = 2'b10,
    SEL_DRIVE_HI = 2'b11
  } sel_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MASTER = 2'b01,
    ST_SLAVE = 2'b10
  } eng_state_t;

  localparam sel_mode_t MODE_RESET = sel_mode_t'(CTRL_RESET[MODE_HI:MODE_LO]);
  localparam logic TXE_RESET = CTRL_RESET[TXE_BIT];

  // ----------------------------------------
  // data path and timing
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCK_HALF_NS = 20;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SCK_HALF_LOAD = 3'(SCK_HALF_CYCLES - 1);
  // synchroniser idle levels, order {nss, miso, mosi, sck}
  localparam logic [3:0] SYNC_RESET = 4'h8;

endpackage

/* verification/link_peer.sv */
// Purpose: far side of the serial link, as selected slave or as external master
// Assumes: clock mode 0, msb first, select low while a frame runs
// Notes: released data lines show the inverse of their last level
`timescale 1ns/1ps
`default_nettype none
module link_peer (
  // pins driven by the port
  input wire logic sck_out,
  input wire logic mosi_out,
  input wire logic miso_out,
  input wire logic nss_pin,
  // pins driven by the peer
  output logic sck_in,
  output logic mosi_in,
  output logic miso_in
);
  logic [7:0] reply_q = 8'h00;
  logic [7:0] m_rx = 8'h00;
  logic [7:0] s_rx = 8'h00;
  int m_bits = 0;
  int m_cnt = 0;

  initial begin
    sck_in = 1'b0;
    mosi_in = 1'b0;
    miso_in = 1'b1;
  end

  // selected slave: capture mosi on each rise, count whole bytes
  always @(posedge sck_out) begin
    if (nss_pin === 1'b0) begin
      m_rx = {m_rx[6:0], mosi_out};
      m_bits = m_bits + 1;
      if (m_bits % 8 == 0) m_cnt = m_cnt + 1;
    end
  end

  // next reply bit after each fall; deselected line keeps changing
  always @(negedge sck_out or nss_pin) begin
    if (nss_pin === 1'b0) miso_in = reply_q[7 - (m_bits % 8)];
    else miso_in = ~miso_in;
  end

  // external master frame, 48 ns link clock, clock stands low between frames
  task automatic drive_frame(input logic [7:0] b);
    #7;
    for (int i = 7; i >= 0; i--) begin
      mosi_in = b[i];
      #24 sck_in = 1'b1;
      s_rx = {s_rx[6:0], miso_out};
      #24 sck_in = 1'b0;
    end
    mosi_in = ~b[0];
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Purpose: self-checking bench for the serial port control/status block
// Assumes: reads answer one cycle after the read strobe
// Notes: read results checked by a monitor against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import serial_port_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic sfr_bit_wr = 1'b0;
  logic [2:0] sfr_bit_idx = 3'h0;
  logic sfr_bit_val = 1'b0;
  logic int_enable = 1'b0;
  logic nss_drv = 1'b1;
  logic rd_seen = 1'b0;
  logic [7:0] sfr_rdata, d, r, t;
  logic [7:0] b [9];
  logic irq, sck_out, sck_oe_b, mosi_out, mosi_oe_b, miso_out, miso_oe_b, nss_out, nss_oe_b;
  logic sck_in, mosi_in, miso_in;
  wire logic nss_pin;
  logic [7:0] exp_q [$];
  int checked = 0;
  int fail_count = 0;
  int seed;

  // select pin level from both parties, pull-up otherwise
  assign nss_pin = (nss_oe_b === 1'b0) ? nss_out : nss_drv;

  // system clock
  always #2 ref_clk = ~ref_clk;

  serial_port_ctrl i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
    .int_enable(int_enable), .irq(irq), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe_b(sck_oe_b), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_b(mosi_oe_b),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe_b(miso_oe_b), .nss_in(nss_pin),
    .nss_out(nss_out), .nss_oe_b(nss_oe_b));

  link_peer i_peer (.sck_out(sck_out), .mosi_out(mosi_out), .miso_out(miso_out),
    .nss_pin(nss_pin), .sck_in(sck_in), .mosi_in(mosi_in), .miso_in(miso_in));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one bus cycle: 0 idle, 1 write, 2 read, 3 bit write (v[3] value, v[2:0] index)
  task automatic op(input logic [1:0] k, input logic [7:0] a, input logic [7:0] v);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_bit_idx <= v[2:0];
    sfr_bit_val <= v[3];
    sfr_wr <= (k == 2'd1);
    sfr_rd <= (k == 2'd2);
    sfr_bit_wr <= (k == 2'd3);
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    op(2'd1, a, v);
    op(2'd0, a, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    op(2'd2, a, 8'h00);
    op(2'd0, a, 8'h00);
  endtask

  task automatic wait_bytes(input int n);
    int k;
    k = 0;
    while (i_peer.m_cnt < n && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 3000) begin
      fail_count++;
      $display("MISMATCH at %0t: transfer never ended", $time);
      tally_and_finish();
    end
    repeat (12) @(posedge ref_clk);
  endtask

  // read monitor: oldest note against the answer one cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) check(sfr_rdata, 8'hXX);
      else check(sfr_rdata, exp_q.pop_front());
    end
    rd_seen <= sfr_rd;
  end

  // hang guard
  initial begin
    #200000;
    fail_count++;
    $display("MISMATCH at %0t: run hung", $time);
    tally_and_finish();
  end

  // main sequence
  initial begin
    seed = $urandom(29);
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(CTRL_ADDR, CTRL_RESET);
    rd(8'h00, 8'h00);
    check(8'(nss_oe_b), 8'h01);
    wr(CTRL_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'h02);
    check(8'(nss_oe_b), 8'h01);
    // master with select driven low, back-to-back data writes
    // reply set before select falls, so its first bit is already on the line
    d = 8'($urandom);
    r = 8'($urandom);
    i_peer.reply_q = r;
    wr(CFG_ADDR, 8'h40);
    wr(CTRL_ADDR, 8'h09);
    int_enable <= 1'b1;
    // pin enables follow the mode one cycle later
    @(posedge ref_clk);
    check(8'(nss_oe_b), 8'h00);
    check(8'(nss_out), 8'h00);
    check(8'(sck_oe_b), 8'h00);
    op(2'd1, DATA_ADDR, d);
    op(2'd1, DATA_ADDR, ~d);
    op(2'd0, DATA_ADDR, 8'h00);
    wait_bytes(1);
    check(i_peer.m_rx, d);
    rd(CTRL_ADDR, 8'hCB);
    check(8'(irq), 8'h01);
    rd(DATA_ADDR, r);
    rd(DATA_ADDR, 8'h00);
    op(2'd3, CTRL_ADDR, 8'h07);
    op(2'd0, CTRL_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'h4B);
    check(8'(irq), 8'h01);
    wr(CTRL_ADDR, 8'h09);
    @(posedge ref_clk);
    check(8'(irq), 8'h00);
    op(2'd3, CTRL_ADDR, 8'h0A);
    op(2'd0, CTRL_ADDR, 8'h00);
    @(posedge ref_clk);
    check(8'(nss_out), 8'h01);
    // select pulled low in multi-master mode
    wr(CTRL_ADDR, 8'h05);
    nss_drv <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd(CTRL_ADDR, 8'h27);
    check(8'(nss_oe_b), 8'h01);
    nss_drv <= 1'b1;
    repeat (5) @(posedge ref_clk);
    wr(CTRL_ADDR, 8'h05);
    rd(CTRL_ADDR, 8'h07);
    // slave: nine frames into an eight-deep buffer
    wr(CFG_ADDR, 8'h00);
    nss_drv <= 1'b0;
    t = 8'($urandom);
    wr(DATA_ADDR, t);
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      b[i] = 8'($urandom);
      i_peer.drive_frame(b[i]);
      if (i == 0) check(i_peer.s_rx, t);
    end
    @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    rd(CTRL_ADDR, 8'h97);
    for (int i = 0; i < 8; i++) rd(DATA_ADDR, b[i]);
    nss_drv <= 1'b1;
    // disabled port holds a written byte
    wr(CTRL_ADDR, 8'h00);
    wr(CFG_ADDR, 8'h40);
    wr(DATA_ADDR, 8'h5A);
    repeat (20) @(posedge ref_clk);
    check(8'(sck_oe_b), 8'h01);
    rd(CTRL_ADDR, 8'h00);
    repeat (4) @(posedge ref_clk);
    check(8'(exp_q.size()), 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
